// *** rtl/bcc_pkg.sv ***
// Purpose: shared constants, opcodes and decode helpers for the branch and cycle control
// Assumes: clk is the oscillator clock, one clock per oscillator period
// Notes:   opcode values are the core's fixed encodings
package bcc_pkg;

    // machine cycle shape
    localparam int unsigned   OSC_PERIOD_NS         = 10;
    localparam int unsigned   OSC_PERIODS_PER_STATE = 2;
    localparam int unsigned   STATES_PER_MC         = 6;
    localparam int unsigned   MC_OSC_PERIODS        = OSC_PERIODS_PER_STATE * STATES_PER_MC;
    localparam logic [2:0]    ST_S1                 = 3'h0;
    localparam logic [2:0]    ST_S4                 = 3'h3;
    localparam logic [2:0]    ST_S6                 = 3'h5;
    localparam logic          PH_P1                 = 1'b0;
    localparam logic          PH_P2                 = 1'b1;

    // reset values
    localparam logic [15:0]   RST_PC                = 16'h0000;
    localparam logic [7:0]    RST_IR                = 8'h00;
    localparam int unsigned   STACK_AW              = 4;
    localparam logic [3:0]    RST_SP                = 4'h0;

    // opcodes
    localparam logic [7:0]    OP_SRJ                = 8'h80;
    localparam logic [7:0]    OP_LAJ                = 8'h02;
    localparam logic [7:0]    OP_LSC                = 8'h12;
    localparam logic [7:0]    OP_SRT                = 8'h22;
    localparam logic [7:0]    OP_IRT                = 8'h32;
    localparam logic [7:0]    OP_JMP_IDX            = 8'h73;
    localparam logic [7:0]    OP_BAZ                = 8'h60;
    localparam logic [7:0]    OP_BANZ               = 8'h70;
    localparam logic [7:0]    OP_DBN_DIR            = 8'hd5;
    localparam logic [7:0]    OP_CBU_AIMM           = 8'hb4;
    localparam logic [7:0]    OP_CBU_ADIR           = 8'hb5;
    localparam logic [4:0]    PG_JUMP_LO            = 5'h01;
    localparam logic [4:0]    PG_CALL_LO            = 5'h11;
    localparam logic [4:0]    DBN_REG_HI            = 5'h1b;
    localparam logic [6:0]    CBU_IND_HI            = 7'h5b;
    localparam logic [4:0]    CBU_REG_HI            = 5'h17;

    typedef enum logic [1:0] {
        MC_FIRST  = 2'b00,
        MC_SECOND = 2'b01
    } bcc_mc_t;

    // pc-relative target, offset is two's complement
    function automatic logic [15:0] bcc_rel_target(input logic [15:0] pc, input logic [7:0] off);
        return pc + {{8{off[7]}}, off};
    endfunction : bcc_rel_target

    // low 11 bits replaced, 2k block kept
    function automatic logic [15:0] bcc_page_target(input logic [15:0] pc,
                                                    input logic [7:0]  op,
                                                    input logic [7:0]  lo);
        return {pc[15:11], op[7:5], lo};
    endfunction : bcc_page_target

    function automatic logic bcc_is_page(input logic [7:0] op);
        return (op[4:0] == PG_JUMP_LO) || (op[4:0] == PG_CALL_LO);
    endfunction : bcc_is_page

    function automatic logic bcc_is_dbn(input logic [7:0] op);
        return (op == OP_DBN_DIR) || (op[7:3] == DBN_REG_HI);
    endfunction : bcc_is_dbn

    function automatic logic bcc_is_cbu(input logic [7:0] op);
        return (op == OP_CBU_AIMM) || (op == OP_CBU_ADIR) ||
               (op[7:1] == CBU_IND_HI) || (op[7:3] == CBU_REG_HI);
    endfunction : bcc_is_cbu

    // external data moves: e0, e2, e3, f0, f2, f3
    function automatic logic bcc_is_xmove(input logic [7:0] op);
        return (op[7:5] == 3'h7) && ((op[3:0] == 4'h0) || (op[3:0] == 4'h2) ||
                                     (op[3:0] == 4'h3));
    endfunction : bcc_is_xmove

    // byte count of an instruction
    function automatic logic [1:0] bcc_len(input logic [7:0] op);
        if ((op == OP_LAJ) || (op == OP_LSC) || (op == OP_DBN_DIR) || bcc_is_cbu(op)) begin
            return 2'd3;
        end
        if ((op == OP_SRJ) || bcc_is_page(op) || (op == OP_BAZ) || (op == OP_BANZ) ||
            bcc_is_dbn(op)) begin
            return 2'd2;
        end
        return 2'd1;
    endfunction : bcc_len

    function automatic logic bcc_two_mc(input logic [7:0] op);
        return (bcc_len(op) != 2'd1) || (op == OP_SRT) || (op == OP_IRT) ||
               (op == OP_JMP_IDX) || bcc_is_xmove(op);
    endfunction : bcc_two_mc

endpackage : bcc_pkg

// *** rtl/bcc_cycle_timer.sv ***
// Purpose: six-state, two-phase machine cycle sequencer
// Assumes: one clk per oscillator period
// Notes:   state and phase leave straight from flip-flops
`timescale 1ns/1ns
`default_nettype none
module bcc_cycle_timer (
    input  wire logic       clk,
    input  wire logic       rst_n,
    output var  logic [2:0] state_ff,
    output var  logic       phase_ff
);
    logic [2:0] nxt_state;
    logic       nxt_phase;

    // each state spends one period in each phase, so 12 periods per cycle
    always_comb begin
        nxt_phase = ~phase_ff;
        nxt_state = state_ff;
        if (phase_ff == bcc_pkg::PH_P2) begin
            nxt_state = (state_ff == bcc_pkg::ST_S6) ? bcc_pkg::ST_S1
                                                     : state_ff + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= bcc_pkg::ST_S1;
            phase_ff <= bcc_pkg::PH_P1;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
        end
    end
endmodule : bcc_cycle_timer
`default_nettype wire

// *** rtl/bcc_ret_stack.sv ***
// Purpose: return address store for calls
// Assumes: one write and one read port, read data registered
// Notes:   contents are not reset; pointer lives in the caller
`timescale 1ns/1ns
`default_nettype none
module bcc_ret_stack (
    input  wire logic        clk,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [3:0]  rd_addr,
    output var  logic [15:0] rd_data_ff
);
    logic [15:0] mem_ff [16];

    // write port
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    // registered read, always tracking the top entry
    always_ff @(posedge clk) begin
        rd_data_ff <= mem_ff[rd_addr];
    end
endmodule : bcc_ret_stack
`default_nettype wire

// *** rtl/bcc_branch_ctrl.sv ***
// Purpose: program fetch sequencing and control-flow execution of the core
// Assumes: code_data is valid in the clock where code_rd_ff is high
// Notes:   operand bytes from data space come in already resolved on opnd_data
//
// Functional notes
// - short jump: opcode plus signed offset, reach -128..+127 from next instruction
// - offset is two's complement, added to pc only when jump taken
// - long jump: opcode plus two bytes, full 16-bit target
// - page jump: three target bits in opcode, low eight in next byte
// - page jump swaps low 11 pc bits, keeps high 5
// - indexed jump: pc gets data pointer plus accumulator
// - long call takes full 16-bit target anywhere in 64k
// - page call substitutes 11 bits like page jump
// - return resumes after the call using its saved address
// - interrupt return also tells interrupt logic the service is done
// - with no interrupt in service, interrupt return equals plain return
// - all conditional branches use a relative offset
// - no zero flag; acc zero branches test accumulator directly
// - decrement byte operand, branch only when result nonzero
// - compare two bytes, branch only when unequal, four operand forms
// - compare is unsigned: carry set when first is smaller
// - machine cycle is six states of two periods, 12 periods
// - each state has a first and second phase half
// - two fetches per cycle; unneeded byte dropped, pc not advanced
// - opcode latched in first state, second fetch in fourth, ends after sixth
// - external data move takes two cycles, second one fetches nothing
`timescale 1ns/1ns
`default_nettype none
module bcc_branch_ctrl (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  code_data,
    input  wire logic [7:0]  acc,
    input  wire logic [15:0] data_pointer,
    input  wire logic [7:0]  opnd_data,
    input  wire logic        int_in_service,
    output var  logic [15:0] code_addr_ff,
    output var  logic        code_rd_ff,
    output var  logic [15:0] pc_ff,
    output var  logic [7:0]  ir_ff,
    output var  logic [2:0]  state_ff,
    output var  logic        phase_ff,
    output var  logic        ext_move_ff,
    output var  logic        int_done_ff,
    output var  logic        carry_ff,
    output var  logic        carry_we_ff,
    output var  logic [7:0]  dec_val_ff,
    output var  logic        dec_we_ff
);
    bcc_pkg::bcc_mc_t mc_ff, nxt_mc;
    logic [1:0]  got_ff, nxt_got;
    logic [7:0]  b1_ff, nxt_b1;
    logic [7:0]  b2_ff, nxt_b2;
    logic        need_ff, nxt_need;
    logic [3:0]  sp_ff, nxt_sp;
    logic [15:0] nxt_pc, nxt_code_addr;
    logic [7:0]  nxt_ir, nxt_dec_val;
    logic        nxt_code_rd, nxt_ext_move, nxt_int_done;
    logic        nxt_carry, nxt_carry_we, nxt_dec_we;
    logic        slot_p1, first_slot, cyc_end, last_mc, exec;
    logic        stk_we;
    logic [15:0] stk_rdata;
    logic [15:0] rel_b1, rel_b2;
    logic [7:0]  dec_res, cmp_a, cmp_b;

    bcc_cycle_timer u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .state_ff (state_ff),
        .phase_ff (phase_ff)
    );

    bcc_ret_stack u_stack (
        .clk        (clk),
        .wr_en      (stk_we),
        .wr_addr    (sp_ff),
        .wr_data    (pc_ff),
        .rd_addr    (sp_ff - 4'h1),
        .rd_data_ff (stk_rdata)
    );

    // timing points within the machine cycle
    assign slot_p1    = (phase_ff == bcc_pkg::PH_P1) &&
                        ((state_ff == bcc_pkg::ST_S1) || (state_ff == bcc_pkg::ST_S4));
    assign first_slot = (mc_ff == bcc_pkg::MC_FIRST) && (state_ff == bcc_pkg::ST_S1);
    assign cyc_end    = (state_ff == bcc_pkg::ST_S6) && (phase_ff == bcc_pkg::PH_P2);
    assign last_mc    = (mc_ff == bcc_pkg::MC_SECOND) || !bcc_pkg::bcc_two_mc(ir_ff);
    assign exec       = cyc_end && last_mc;

    // operand arithmetic; pc already points past all instruction bytes here
    assign rel_b1  = bcc_pkg::bcc_rel_target(pc_ff, b1_ff);
    assign rel_b2  = bcc_pkg::bcc_rel_target(pc_ff, b2_ff);
    assign dec_res = opnd_data - 8'h01;
    // first byte is acc for the acc forms, else the register or indirect byte
    assign cmp_a   = ((ir_ff == bcc_pkg::OP_CBU_AIMM) || (ir_ff == bcc_pkg::OP_CBU_ADIR))
                     ? acc : opnd_data;
    assign cmp_b   = (ir_ff == bcc_pkg::OP_CBU_ADIR) ? opnd_data : b1_ff;

    // fetch, decode and execute next-state
    always_comb begin
        nxt_mc        = mc_ff;
        nxt_got       = got_ff;
        nxt_b1        = b1_ff;
        nxt_b2        = b2_ff;
        nxt_need      = need_ff;
        nxt_sp        = sp_ff;
        nxt_pc        = pc_ff;
        nxt_ir        = ir_ff;
        nxt_code_addr = code_addr_ff;
        nxt_code_rd   = 1'b0;
        nxt_ext_move  = ext_move_ff;
        nxt_int_done  = 1'b0;
        nxt_carry     = carry_ff;
        nxt_carry_we  = 1'b0;
        nxt_dec_val   = dec_val_ff;
        nxt_dec_we    = 1'b0;
        stk_we        = 1'b0;
        // fetch slots in s1 and s4, skipped only in a data move's second cycle
        if (slot_p1 && !(ext_move_ff && (mc_ff == bcc_pkg::MC_SECOND))) begin
            nxt_code_rd   = 1'b1;
            nxt_code_addr = pc_ff;
            nxt_need      = first_slot || (got_ff < bcc_pkg::bcc_len(ir_ff));
        end
        // a byte nobody needs is dropped and pc stays put
        if (code_rd_ff && need_ff) begin
            nxt_pc  = pc_ff + 16'h0001;
            nxt_got = got_ff + 2'd1;
            unique case (got_ff)
                2'd0:    nxt_ir = code_data;
                2'd1:    nxt_b1 = code_data;
                default: nxt_b2 = code_data;
            endcase
        end
        if (cyc_end) begin
            nxt_mc       = last_mc ? bcc_pkg::MC_FIRST : bcc_pkg::MC_SECOND;
            nxt_ext_move = !last_mc && bcc_pkg::bcc_is_xmove(ir_ff);
        end
        // control flow takes effect at the end of the last cycle
        if (exec) begin
            nxt_got = 2'd0;
            if (ir_ff == bcc_pkg::OP_SRJ) begin
                nxt_pc = rel_b1;
            end else if (ir_ff == bcc_pkg::OP_LAJ) begin
                nxt_pc = {b1_ff, b2_ff};
            end else if (bcc_pkg::bcc_is_page(ir_ff)) begin
                stk_we = ir_ff[4];
                nxt_sp = ir_ff[4] ? sp_ff + 4'h1 : sp_ff;
                nxt_pc = bcc_pkg::bcc_page_target(pc_ff, ir_ff, b1_ff);
            end else if (ir_ff == bcc_pkg::OP_LSC) begin
                stk_we = 1'b1;
                nxt_sp = sp_ff + 4'h1;
                nxt_pc = {b1_ff, b2_ff};
            end else if (ir_ff == bcc_pkg::OP_JMP_IDX) begin
                nxt_pc = data_pointer + {8'h00, acc};
            end else if ((ir_ff == bcc_pkg::OP_SRT) || (ir_ff == bcc_pkg::OP_IRT)) begin
                nxt_sp       = sp_ff - 4'h1;
                nxt_pc       = stk_rdata;
                nxt_int_done = (ir_ff == bcc_pkg::OP_IRT) && int_in_service;
            end else if ((ir_ff == bcc_pkg::OP_BAZ) || (ir_ff == bcc_pkg::OP_BANZ)) begin
                // no zero flag exists, the accumulator itself is tested
                if ((acc == 8'h00) == (ir_ff == bcc_pkg::OP_BAZ)) begin
                    nxt_pc = rel_b1;
                end
            end else if (bcc_pkg::bcc_is_dbn(ir_ff)) begin
                nxt_dec_val = dec_res;
                nxt_dec_we  = 1'b1;
                if (dec_res != 8'h00) begin
                    nxt_pc = (ir_ff == bcc_pkg::OP_DBN_DIR) ? rel_b2 : rel_b1;
                end
            end else if (bcc_pkg::bcc_is_cbu(ir_ff)) begin
                nxt_carry    = cmp_a < cmp_b;
                nxt_carry_we = 1'b1;
                if (cmp_a != cmp_b) begin
                    nxt_pc = rel_b2;
                end
            end
            // untaken branches keep pc as advanced by the fetches
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mc_ff        <= bcc_pkg::MC_FIRST;
            got_ff       <= 2'd0;
            b1_ff        <= 8'h00;
            b2_ff        <= 8'h00;
            need_ff      <= 1'b0;
            sp_ff        <= bcc_pkg::RST_SP;
            pc_ff        <= bcc_pkg::RST_PC;
            ir_ff        <= bcc_pkg::RST_IR;
            code_addr_ff <= bcc_pkg::RST_PC;
            code_rd_ff   <= 1'b0;
            ext_move_ff  <= 1'b0;
            int_done_ff  <= 1'b0;
            carry_ff     <= 1'b0;
            carry_we_ff  <= 1'b0;
            dec_val_ff   <= 8'h00;
            dec_we_ff    <= 1'b0;
        end else begin
            mc_ff        <= nxt_mc;
            got_ff       <= nxt_got;
            b1_ff        <= nxt_b1;
            b2_ff        <= nxt_b2;
            need_ff      <= nxt_need;
            sp_ff        <= nxt_sp;
            pc_ff        <= nxt_pc;
            ir_ff        <= nxt_ir;
            code_addr_ff <= nxt_code_addr;
            code_rd_ff   <= nxt_code_rd;
            ext_move_ff  <= nxt_ext_move;
            int_done_ff  <= nxt_int_done;
            carry_ff     <= nxt_carry;
            carry_we_ff  <= nxt_carry_we;
            dec_val_ff   <= nxt_dec_val;
            dec_we_ff    <= nxt_dec_we;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // cycle end recurs every 12 clocks
    sequence s_mc_gap;
        (!cyc_end) [*8] ##1 (!cyc_end) [*3] ##1 cyc_end;
    endsequence

    // fetch strobes six clocks apart, s1 then s4
    sequence s_fetch_pair;
        code_rd_ff ##6 code_rd_ff;
    endsequence

    a_cycle_length:
        assert property (cyc_end |=> s_mc_gap)
        else $error("machine cycle is not 12 clocks");

    a_fetch_slots:
        assert property (first_slot && (phase_ff == bcc_pkg::PH_P2) |-> s_fetch_pair)
        else $error("fetch strobes missing in s1 or s4");

    a_xmove_gap:
        assert property (ext_move_ff && (mc_ff == bcc_pkg::MC_SECOND) |-> !code_rd_ff)
        else $error("fetch issued in data move second cycle");

    a_unneeded_hold:
        assert property (code_rd_ff && !need_ff && !exec |=> pc_ff == $past(pc_ff))
        else $error("pc moved on a discarded fetch");

    a_short_jump:
        assert property (exec && (ir_ff == bcc_pkg::OP_SRJ)
            |=> pc_ff == bcc_pkg::bcc_rel_target($past(pc_ff), $past(b1_ff)))
        else $error("short jump target wrong");

    a_page_keep:
        assert property (exec && bcc_pkg::bcc_is_page(ir_ff)
            |=> (pc_ff[15:11] == $past(pc_ff[15:11])) &&
                (pc_ff[10:0] == {$past(ir_ff[7:5]), $past(b1_ff)}))
        else $error("page target wrong");

    a_long_target:
        assert property (exec && ((ir_ff == bcc_pkg::OP_LAJ) || (ir_ff == bcc_pkg::OP_LSC))
            |=> pc_ff == {$past(b1_ff), $past(b2_ff)})
        else $error("long target wrong");

    a_indexed_jump:
        assert property (exec && (ir_ff == bcc_pkg::OP_JMP_IDX)
            |=> pc_ff == $past(data_pointer) + {8'h00, $past(acc)})
        else $error("indexed jump target wrong");

    a_return_pop:
        assert property (exec && ((ir_ff == bcc_pkg::OP_SRT) || (ir_ff == bcc_pkg::OP_IRT))
            |=> (pc_ff == $past(stk_rdata)) && (sp_ff == $past(sp_ff) - 4'h1))
        else $error("return did not pop saved address");

    a_interrupt_return_done:
        assert property (int_done_ff ==
            $past(exec && (ir_ff == bcc_pkg::OP_IRT) && int_in_service))
        else $error("service done pulse wrong");

    a_acc_branch:
        assert property (exec && (ir_ff == bcc_pkg::OP_BAZ)
            |=> pc_ff == (($past(acc) == 8'h00) ? $past(rel_b1) : $past(pc_ff)))
        else $error("acc zero branch wrong");

    a_acc_nonzero:
        assert property (exec && (ir_ff == bcc_pkg::OP_BANZ)
            |=> pc_ff == (($past(acc) != 8'h00) ? $past(rel_b1) : $past(pc_ff)))
        else $error("acc nonzero branch wrong");

    a_dec_write:
        assert property (exec && bcc_pkg::bcc_is_dbn(ir_ff)
            |=> dec_we_ff && (dec_val_ff == $past(opnd_data) - 8'h01))
        else $error("decrement result wrong");

    a_cmp_carry:
        assert property (exec && bcc_pkg::bcc_is_cbu(ir_ff)
            |=> carry_we_ff && (carry_ff == ($past(cmp_a) < $past(cmp_b))))
        else $error("compare carry wrong");

endmodule : bcc_branch_ctrl
`default_nettype wire

// *** sim/bcc_code_mem.sv ***
// Purpose: behavioural program memory facing the fetch port
// Assumes: no handshake, the byte is shown while the fetch strobe is high
// Notes:   outside a fetch the bus toggles so a stale byte never looks valid
`timescale 1ns/1ns
`default_nettype none
module bcc_code_mem (
    input  wire logic        clk,
    input  wire logic        code_rd_ff,
    input  wire logic [15:0] code_addr_ff,
    output var  logic [7:0]  code_data
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_ff = 8'h5a;
    // blank memory reads as one-byte no-ops
    initial begin
        for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    end
    // idle bus shows the inverse of the last byte, changing every clock
    always_ff @(posedge clk) begin
        last_ff <= code_data;
    end
    assign code_data = code_rd_ff ? mem[code_addr_ff] : ~last_ff;
endmodule : bcc_code_mem
`default_nettype wire

// *** sim/bcc_branch_ctrl_bench.sv ***
// Purpose: self-checking bench for the branch and machine cycle control
// Assumes: each instruction is placed at the pc just before its opcode fetch
// Notes:   return addresses are mirrored in a bench queue, kept below 16 deep
`timescale 1ns/1ns
`default_nettype none
module bcc_branch_ctrl_bench;
    logic        clk = 1'b0, rst_n = 1'b0, int_in_service = 1'b0;
    logic [7:0]  acc = 8'h00, opnd_data = 8'h00, code_data, ir_ff, dec_val_ff, e_dv;
    logic [15:0] data_pointer = 16'h0000, code_addr_ff, pc_ff, e_pc;
    logic [2:0]  state_ff;
    logic        code_rd_ff, phase_ff, ext_move_ff, int_done_ff, carry_ff, carry_we_ff, dec_we_ff;
    logic        e_done, e_cwe, e_c, e_dwe, e_mv;
    logic [15:0] stk [$];
    int          e_mc, bad_count = 0, samples_checked = 0, cycles = 0;
    logic [7:0]  ops [23] = '{8'h80, 8'h02, 8'h12, 8'h22, 8'h32, 8'h73, 8'h60, 8'h70, 8'hd5,
        8'hd8, 8'hb4, 8'hb5, 8'hb6, 8'hb8, 8'h01, 8'h11, 8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2,
        8'hf3, 8'h00};

    always #5 clk = ~clk;

    bcc_code_mem u_mem (.clk(clk), .code_rd_ff(code_rd_ff), .code_addr_ff(code_addr_ff),
        .code_data(code_data));
    bcc_branch_ctrl u_dut (.clk(clk), .rst_n(rst_n), .code_data(code_data), .acc(acc),
        .data_pointer(data_pointer), .opnd_data(opnd_data), .int_in_service(int_in_service),
        .code_addr_ff(code_addr_ff), .code_rd_ff(code_rd_ff), .pc_ff(pc_ff), .ir_ff(ir_ff),
        .state_ff(state_ff), .phase_ff(phase_ff), .ext_move_ff(ext_move_ff),
        .int_done_ff(int_done_ff), .carry_ff(carry_ff), .carry_we_ff(carry_we_ff),
        .dec_val_ff(dec_val_ff), .dec_we_ff(dec_we_ff));

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_n(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            bad_count++;
            $display("ERROR %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : chk_n

    function automatic logic [15:0] rel(input logic [15:0] n, input logic [7:0] off);
        return n + {{8{off[7]}}, off};
    endfunction : rel

    // expected pc, cycle count and side results from the driven operands
    function automatic void predict(input logic [7:0] op, b1, b2, input logic [15:0] p);
        logic [7:0] a, b;
        a = acc;
        b = b1;
        {e_done, e_cwe, e_dwe, e_mv} = 4'h0;
        e_mc = 2;
        e_pc = p + 16'd2;
        casez (op)
            8'h02, 8'h12: begin
                if (op == 8'h12) stk.push_back(p + 16'd3);
                e_pc = {b1, b2};
            end
            8'h22, 8'h32: begin
                e_pc = stk.pop_back();
                e_done = (op == 8'h32) && int_in_service;
            end
            8'h73: e_pc = data_pointer + {8'h00, acc};
            8'h80: e_pc = rel(e_pc, b1);
            8'h60: if (acc == 8'h00) e_pc = rel(e_pc, b1);
            8'h70: if (acc != 8'h00) e_pc = rel(e_pc, b1);
            8'hd5, 8'b11011???: begin
                e_dwe = 1'b1;
                e_dv = opnd_data - 8'h01;
                if (op == 8'hd5) e_pc = p + 16'd3;
                if (e_dv != 8'h00) e_pc = rel(e_pc, (op == 8'hd5) ? b2 : b1);
            end
            8'hb4, 8'hb5, 8'b1011011?, 8'b10111???: begin
                if (op == 8'hb5) b = opnd_data;
                if (op > 8'hb5) a = opnd_data;
                e_cwe = 1'b1;
                e_c = a < b;
                e_pc = p + 16'd3;
                if (a != b) e_pc = rel(e_pc, b2);
            end
            8'b???00001: e_pc = {e_pc[15:11], op[7:5], b1};
            8'b???10001: begin
                stk.push_back(e_pc);
                e_pc = {e_pc[15:11], op[7:5], b1};
            end
            8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3: begin
                e_mv = 1'b1;
                e_pc = p + 16'd1;
            end
            default: begin
                e_mc = 1;
                e_pc = p + 16'd1;
            end
        endcase
    endfunction : predict

    // one instruction from s1p1 to the next s1p1, sampled at falling edges
    task automatic run_one(input logic [7:0] op, b1, b2, a, o, input logic [15:0] dp,
                           input logic ins);
        logic [15:0] p;
        logic [7:0]  dv;
        logic        c;
        int          nf, pos, em, dn, cw, dw;
        p = pc_ff;
        {nf, pos, em, dn, cw, dw} = '0;
        u_mem.mem[p] = op;
        u_mem.mem[p + 16'd1] = b1;
        u_mem.mem[p + 16'd2] = b2;
        @(posedge clk);
        acc <= a;
        opnd_data <= o;
        data_pointer <= dp;
        int_in_service <= ins;
        #1;
        predict(op, b1, b2, p);
        for (int k = 1; k <= 12 * e_mc; k++) begin
            @(negedge clk);
            if (k == 1) chk(code_addr_ff, p);
            if (k == 2) chk({8'h00, ir_ff}, {8'h00, op});
            if (code_rd_ff === 1'b1) nf++;
            if (code_rd_ff === 1'b1 && !(phase_ff === bcc_pkg::PH_P2 &&
                (state_ff === bcc_pkg::ST_S1 || state_ff === bcc_pkg::ST_S4))) pos++;
            if (int_done_ff === 1'b1) dn++;
            if (ext_move_ff === 1'b1) em++;
            if (carry_we_ff === 1'b1) {cw, c} = {cw + 1, carry_ff};
            if (dec_we_ff === 1'b1) {dw, dv} = {dw + 1, dec_val_ff};
        end
        chk(pc_ff, e_pc);
        chk({12'h000, state_ff, phase_ff}, 16'h0000);
        chk_n(nf, e_mv ? 2 : 2 * e_mc);
        chk_n(pos, 0);
        chk_n(em > 0, e_mv);
        chk_n(dn, e_done);
        chk_n(cw, e_cwe);
        if (e_cwe) chk({15'h0000, c}, {15'h0000, e_c});
        chk_n(dw, e_dwe);
        if (e_dwe) chk({8'h00, dv}, {8'h00, e_dv});
    endtask : run_one

    // hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("ERROR %0t run did not finish", $time);
            finish_test();
        end
    end

    initial begin
        logic [7:0] op, b1, a, o;
        void'($urandom(32'h1b06_c79e));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        do @(negedge clk); while (state_ff !== bcc_pkg::ST_S4);
        do @(negedge clk); while (state_ff !== bcc_pkg::ST_S1 || phase_ff !== bcc_pkg::PH_P1);
        run_one(8'h02, 8'h07, 8'hfe, 8'h00, 8'h00, 16'h0000, 1'b0);
        run_one(8'he1, 8'h34, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0);
        run_one(8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0);
        run_one(8'h80, 8'h7f, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0);
        run_one(8'h12, 8'hab, 8'hcd, 8'h00, 8'h00, 16'h0000, 1'b0);
        run_one(8'h32, 8'h00, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0);
        run_one(8'hd5, 8'h30, 8'h10, 8'h00, 8'h01, 16'h0000, 1'b0);
        run_one(8'hb4, 8'h10, 8'hf0, 8'h0f, 8'h00, 16'h0000, 1'b0);
        run_one(8'h73, 8'h00, 8'h00, 8'hff, 8'h00, 16'hff80, 1'b0);
        run_one(8'h60, 8'hf0, 8'h00, 8'h00, 8'h00, 16'h0000, 1'b0);
        // random mix, operands biased towards zero, one and equal bytes
        repeat (300) begin
            op = ops[$urandom % 23];
            if (op[4:0] == 5'h01 || op[4:0] == 5'h11) op[7:5] = 3'($urandom);
            if (op == 8'hd8 || op == 8'hb8) op[2:0] = 3'($urandom);
            if (op == 8'hb6) op[0] = 1'($urandom);
            if ((op == 8'h22 || op == 8'h32) && stk.size() == 0) op = 8'h00;
            if ((op == 8'h12 || op[4:0] == 5'h11) && stk.size() >= 15) op = 8'h22;
            b1 = 8'($urandom);
            a = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
            case ($urandom % 4)
                0: o = 8'h01;
                1: o = a;
                2: o = b1;
                default: o = 8'($urandom);
            endcase
            run_one(op, b1, 8'($urandom), a, o, 16'($urandom), 1'($urandom));
        end
        finish_test();
    end
endmodule : bcc_branch_ctrl_bench
`default_nettype wire
